// ---- logic/enis_node.sv ----
// Error node record, interrupt signaling and AXI4-Lite register slave
//
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
// What this block does
// - Level fault irq on enabled deferred/uncorrected record
// - Level fault irq on counter overflow flag
// - Level fault irq on corrected field, no counter
// - Level recovery irq on enabled uncorrected record
// - Level recovery irq on enabled deferred record
// - Level critical irq on enabled critical record
// - Edge fault pulse on enabled uncorrected detection
// - Edge fault pulse on enabled corrected event
// - Edge recovery pulse on enabled uncorrected detection
// - Edge recovery pulse on enabled deferred detection
// - Edge critical pulse per critical record, when enabled
// - Pulse still fires when syndrome is dropped
// - Register writes never cause edge pulses
// - Interrupt outputs follow within two cycles
// - Cold reset clears every piece of state
// - Recovery reset keeps recorded syndrome intact
// - Warm reset leaves error records unchanged
// - Timestamp stored per record when feature set
// - Feature field picks the timebase
// - Timebase is binary, monotonic, fixed rate
// - Critical irq enabled only by control bit
// - Counter overflow, else each corrected error
module enis_node (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               err_rec_rst,
  input  wire enis_pkg::enis_err_t err_in,
  input  wire logic [63:0]        sys_count,
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  output enis_pkg::enis_irq_t     irq_out
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Map a byte address to a register number; 7 means unmapped
  function automatic logic [2:0] reg_sel(input logic [7:0] addr);
    logic [2:0] sel;
    sel = 3'h7;
    unique case (addr)
      enis_pkg::FEAT_OFS:  sel = 3'h0;
      enis_pkg::CTRL_OFS:  sel = 3'h1;
      enis_pkg::STAT_OFS:  sel = 3'h2;
      enis_pkg::SYND_OFS:  sel = 3'h3;
      enis_pkg::CECNT_OFS: sel = 3'h4;
      enis_pkg::TSLO_OFS:  sel = 3'h5;
      enis_pkg::TSHI_OFS:  sel = 3'h6;
      default:             sel = 3'h7;
    endcase
    return sel;
  endfunction

  // Merge write data into an old value under the byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old_val,
                                        input logic [31:0] wdat,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = wdat[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Rank of an error class for record priority
  function automatic logic [1:0] rank(input logic [6:0] st);
    logic [1:0] r;
    r = 2'h0;
    if (st[enis_pkg::STAT_UE]) begin
      r = 2'h3;
    end else if (st[enis_pkg::STAT_DE]) begin
      r = 2'h2;
    end else if (st[enis_pkg::STAT_CE +: 2] != 2'h0) begin
      r = 2'h1;
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [5:0]  ctrl_reg;
  logic [6:0]  status_reg;
  logic [15:0] synd_reg;
  logic [7:0]  cecnt_reg;
  logic [63:0] ts_reg;
  logic [63:0] local_time_reg;
  logic [7:0]  aw_addr_reg;
  logic        aw_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        w_held_reg;

  logic        wr_go;
  logic [2:0]  wr_sel;
  logic [31:0] feat_word;
  logic [63:0] timebase;
  logic        is_ce;
  logic        is_de;
  logic        is_ue;
  logic        ce_event;
  logic        overwrite;
  logic        stat_wr;
  logic [6:0]  stat_clr;
  logic [6:0]  stat_set;
  logic [6:0]  stat_next;
  logic        lvl_fault;
  logic        lvl_recov;
  logic        lvl_crit;
  logic        evt_fault;
  logic        evt_recov;
  logic        evt_crit;

  // ----------------------------------------------------------------
  // Feature word and timebase
  // ----------------------------------------------------------------
  // Read-only view of what this node implements
  always_comb begin
    feat_word = 32'h0000_0000;
    feat_word[enis_pkg::FEAT_TS_POS +: 2] = enis_pkg::FEAT_TS_SEL;
    feat_word[enis_pkg::FEAT_CI_POS +: 2] = enis_pkg::FEAT_CI_SEL;
    feat_word[enis_pkg::FEAT_CNT_POS]     = enis_pkg::FEAT_HAS_CECNT;
  end

  // Feature field selects system count or local cycle count
  assign timebase = (enis_pkg::FEAT_TS_SEL == 2'h1) ? sys_count : local_time_reg;

  // Local timebase: plain binary, one step per clock, never reloaded
  always_ff @(posedge clk) begin
    if (rst) begin
      local_time_reg <= 64'h0;
    end else begin
      local_time_reg <= local_time_reg + 64'h1;
    end
  end

  // ----------------------------------------------------------------
  // Error classification and record update
  // ----------------------------------------------------------------
  assign is_ce = err_in.valid && (err_in.kind == enis_pkg::KIND_CE);
  assign is_de = err_in.valid && (err_in.kind == enis_pkg::KIND_DE);
  assign is_ue = err_in.valid && (err_in.kind == enis_pkg::KIND_UE);

  // With a counter only its overflow counts as an event
  assign ce_event = is_ce && (enis_pkg::FEAT_HAS_CECNT ? (cecnt_reg == enis_pkg::CECNT_MAX)
                                                         : 1'b1);

  // A higher priority record keeps its syndrome; lower ones are dropped
  assign overwrite = err_in.valid && (err_in.kind != enis_pkg::KIND_NONE) &&
                     (!status_reg[enis_pkg::STAT_V] ||
                      (err_in.kind > enis_pkg::enis_kind_t'(rank(status_reg))));

  assign wr_go  = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign wr_sel = reg_sel(aw_addr_reg);
  assign stat_wr = wr_go && (wr_sel == 3'h2) && w_strb_reg[0];

  // Write-one-to-clear mask from software
  assign stat_clr = stat_wr ? w_data_reg[6:0] : 7'h00;

  // Bits hardware sets this cycle; these win over a same-cycle clear
  always_comb begin
    stat_set = 7'h00;
    if (overwrite) begin
      stat_set[enis_pkg::STAT_V]  = 1'b1;
      stat_set[enis_pkg::STAT_UE] = is_ue;
      stat_set[enis_pkg::STAT_DE] = is_de;
      stat_set[enis_pkg::STAT_CE +: 2] = is_ce ? enis_pkg::CE_SINGLE : 2'h0;
    end
    if (err_in.valid && err_in.critical) begin
      stat_set[enis_pkg::STAT_V]  = 1'b1;
      stat_set[enis_pkg::STAT_CI] = 1'b1;
    end
    if (enis_pkg::FEAT_HAS_CECNT && ce_event) begin
      stat_set[enis_pkg::STAT_V]  = 1'b1;
      stat_set[enis_pkg::STAT_OF] = 1'b1;
    end
    stat_next = (status_reg & ~stat_clr) | stat_set;
  end

  // Syndrome record: of the two resets only cold reset clears it
  always_ff @(posedge clk) begin
    if (rst) begin
      status_reg <= enis_pkg::STAT_RESET;
    end else begin
      status_reg <= stat_next;
    end
  end

  // Syndrome word and timestamp of the recorded error
  always_ff @(posedge clk) begin
    if (rst) begin
      synd_reg <= 16'h0;
      ts_reg   <= 64'h0;
    end else if (overwrite) begin
      synd_reg <= err_in.syndrome;
      if (enis_pkg::FEAT_TS_SEL != 2'h0) begin
        ts_reg <= timebase;
      end
    end
  end

  // Corrected error counter, wraps to zero on overflow
  always_ff @(posedge clk) begin
    if (rst) begin
      cecnt_reg <= 8'h00;
    end else if (is_ce) begin
      cecnt_reg <= cecnt_reg + 8'h01;
    end else if (wr_go && (wr_sel == 3'h4) && w_strb_reg[0]) begin
      cecnt_reg <= 8'(merge({24'h0, cecnt_reg}, w_data_reg, w_strb_reg));
    end
  end

  // Control survives nothing: both resets return it to disabled
  always_ff @(posedge clk) begin
    if (rst || err_rec_rst) begin
      ctrl_reg <= enis_pkg::CTRL_RESET;
    end else if (wr_go && (wr_sel == 3'h1) && w_strb_reg[0]) begin
      ctrl_reg <= 6'(merge({26'h0, ctrl_reg}, w_data_reg, w_strb_reg));
    end
  end

  // ----------------------------------------------------------------
  // Interrupt conditions
  // ----------------------------------------------------------------
  // Level terms read only the held registers
  always_comb begin
    lvl_fault = ctrl_reg[enis_pkg::CTRL_FI] && status_reg[enis_pkg::STAT_V] &&
                (status_reg[enis_pkg::STAT_DE] || status_reg[enis_pkg::STAT_UE]);
    if (enis_pkg::FEAT_HAS_CECNT) begin
      lvl_fault = lvl_fault || (ctrl_reg[enis_pkg::CTRL_CFI] &&
                  status_reg[enis_pkg::STAT_V] && status_reg[enis_pkg::STAT_OF]);
    end else begin
      lvl_fault = lvl_fault || (ctrl_reg[enis_pkg::CTRL_CFI] &&
                  status_reg[enis_pkg::STAT_V] &&
                  (status_reg[enis_pkg::STAT_CE +: 2] != 2'h0));
    end
    lvl_recov = (ctrl_reg[enis_pkg::CTRL_UI] && status_reg[enis_pkg::STAT_V] &&
                 status_reg[enis_pkg::STAT_UE]) ||
                (ctrl_reg[enis_pkg::CTRL_DUI] && status_reg[enis_pkg::STAT_V] &&
                 status_reg[enis_pkg::STAT_DE]);
    lvl_crit  = ctrl_reg[enis_pkg::CTRL_CI] && status_reg[enis_pkg::STAT_V] &&
                status_reg[enis_pkg::STAT_CI];
  end

  // Edge terms come from detections only, not register writes
  // They ignore whether the syndrome was kept
  always_comb begin
    evt_fault = (ctrl_reg[enis_pkg::CTRL_FI] && (is_de || is_ue)) ||
                (ctrl_reg[enis_pkg::CTRL_CFI] && ce_event);
    evt_recov = (ctrl_reg[enis_pkg::CTRL_UI] && is_ue) ||
                (ctrl_reg[enis_pkg::CTRL_DUI] && is_de);
    evt_crit  = ctrl_reg[enis_pkg::CTRL_CI] && err_in.valid && err_in.critical;
  end

  // Registered outputs; one cycle per event in edge mode
  always_ff @(posedge clk) begin
    if (rst || err_rec_rst) begin
      irq_out <= '0;
    end else if (ctrl_reg[enis_pkg::CTRL_EDGE]) begin
      irq_out.fault    <= evt_fault;
      irq_out.recovery <= evt_recov;
      irq_out.critical <= evt_crit;
    end else begin
      irq_out.fault    <= lvl_fault;
      irq_out.recovery <= lvl_recov;
      irq_out.critical <= lvl_crit;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channels
  // ----------------------------------------------------------------
  // Address and data are taken in either order, one write at a time
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      aw_held_reg   <= 1'b0;
      aw_addr_reg   <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_held_reg   <= 1'b1;
      aw_addr_reg   <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_held_reg   <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  // Write data holding
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_wready <= 1'b1;
      w_held_reg   <= 1'b0;
      w_data_reg   <= 32'h0;
      w_strb_reg   <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_held_reg   <= 1'b1;
      w_data_reg   <= s_axi_wdata;
      w_strb_reg   <= s_axi_wstrb;
    end else if (wr_go) begin
      w_held_reg   <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  // Write response; read-only and unmapped writes are refused
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= enis_pkg::RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= ((wr_sel == 3'h1) || (wr_sel == 3'h2) || (wr_sel == 3'h4)) ?
                      enis_pkg::RESP_OKAY : enis_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channels
  // ----------------------------------------------------------------
  // Data is sampled at the address handshake; answer the next cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= enis_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= enis_pkg::RESP_OKAY;
      unique case (reg_sel(s_axi_araddr))
        3'h0: s_axi_rdata <= feat_word;
        3'h1: s_axi_rdata <= {26'h0, ctrl_reg};
        3'h2: s_axi_rdata <= {25'h0, status_reg};
        3'h3: s_axi_rdata <= {16'h0, synd_reg};
        3'h4: s_axi_rdata <= {24'h0, cecnt_reg};
        3'h5: s_axi_rdata <= ts_reg[31:0];
        3'h6: s_axi_rdata <= ts_reg[63:32];
        3'h7: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= enis_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule // enis_node

// ---- logic/enis_pkg.sv ----
// Constants and types shared by the error node interrupt signaling block
package enis_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] FEAT_OFS  = 8'h00;
  localparam logic [7:0] CTRL_OFS  = 8'h08;
  localparam logic [7:0] STAT_OFS  = 8'h10;
  localparam logic [7:0] SYND_OFS  = 8'h18;
  localparam logic [7:0] CECNT_OFS = 8'h20;
  localparam logic [7:0] TSLO_OFS  = 8'h28;
  localparam logic [7:0] TSHI_OFS  = 8'h2c;

  // ----------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------
  localparam int CTRL_FI   = 0;
  localparam int CTRL_CFI  = 1;
  localparam int CTRL_UI   = 2;
  localparam int CTRL_DUI  = 3;
  localparam int CTRL_CI   = 4;
  localparam int CTRL_EDGE = 5;
  localparam logic [5:0] CTRL_RESET = 6'h00;

  // ----------------------------------------------------------------
  // Status field positions
  // ----------------------------------------------------------------
  localparam int STAT_V   = 0;
  localparam int STAT_UE  = 1;
  localparam int STAT_DE  = 2;
  localparam int STAT_CE  = 3;
  localparam int STAT_CI  = 5;
  localparam int STAT_OF  = 6;
  localparam logic [6:0] STAT_RESET = 7'h00;
  localparam logic [1:0] CE_SINGLE  = 2'h1;

  // ----------------------------------------------------------------
  // Feature values, fixed by this implementation
  // ----------------------------------------------------------------
  localparam logic [1:0] FEAT_TS_SEL     = 2'h1;  // 01 system count, 10 local
  localparam logic [1:0] FEAT_CI_SEL     = 2'h1;  // Critical interrupt present
  localparam logic       FEAT_HAS_CECNT  = 1'b1;
  localparam int         FEAT_TS_POS     = 0;
  localparam int         FEAT_CI_POS     = 2;
  localparam int         FEAT_CNT_POS    = 4;
  localparam logic [7:0] CECNT_MAX       = 8'hff;

  // ----------------------------------------------------------------
  // AXI responses
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Error report and interrupt carriers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    KIND_NONE = 2'b00,
    KIND_CE   = 2'b01,
    KIND_DE   = 2'b10,
    KIND_UE   = 2'b11
  } enis_kind_t;

  typedef struct packed {
    logic        valid;
    enis_kind_t  kind;
    logic        critical;
    logic [15:0] syndrome;
  } enis_err_t;

  typedef struct packed {
    logic fault;
    logic recovery;
    logic critical;
  } enis_irq_t;

endpackage

// ---- testbench/enis_irq_sink.sv ----
// Model of the system interrupt controller fed by the error node
`timescale 1ns/1ps
module enis_irq_sink #(
  parameter int TARGET_CORE = 0  // Lines go to this core's private interrupt
) (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire enis_pkg::enis_irq_t irq,
  output logic [7:0]               f_cnt,
  output logic [7:0]               r_cnt,
  output logic [7:0]               c_cnt
);
  // Count high cycles: a one-cycle pulse per event makes this the event count
  always_ff @(posedge clk) begin
    if (rst) begin
      f_cnt <= 8'h00;
      r_cnt <= 8'h00;
      c_cnt <= 8'h00;
    end else begin
      f_cnt <= f_cnt + 8'(irq.fault);
      r_cnt <= r_cnt + 8'(irq.recovery);
      c_cnt <= c_cnt + 8'(irq.critical);
    end
  end
endmodule // enis_irq_sink

// ---- testbench/enis_node_bench.sv ----
// Self-checking bench for the error node interrupt signaling block
`timescale 1ns/1ps
module enis_node_bench;
  logic                clk, rst, err_rec_rst;
  enis_pkg::enis_err_t err_in;
  enis_pkg::enis_irq_t irq_out;
  logic [63:0]         sys_count, ts_last;
  logic [31:0]         s_axi_wdata, s_axi_rdata, d;
  logic [7:0]          s_axi_awaddr, s_axi_araddr, f_cnt, r_cnt, c_cnt, f0, r0, c0;
  logic [3:0]          s_axi_wstrb;
  logic [1:0]          s_axi_bresp, s_axi_rresp, r;
  logic                s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                s_axi_rvalid, s_axi_rready;
  int                  err_total, cmp_count, cyc;
  // Rows: control[11:6], kind[5:4], critical[3], expected fault/recovery/critical[2:0]
  logic [11:0]         rows [14] = '{12'h074, 12'h064, 12'h132, 12'h222, 12'h120, 12'h439,
                                     12'h038, 12'h090, 12'h874, 12'h932, 12'ha22, 12'ha30,
                                     12'hc19, 12'h890};

  enis_node dut_u (.*);
  enis_irq_sink sink_u (.clk(clk), .rst(rst), .irq(irq_out), .f_cnt(f_cnt), .r_cnt(r_cnt),
                        .c_cnt(c_cnt));

  // Clock, and a timebase that only counts up in plain binary
  always #10 clk = ~clk;
  always @(posedge clk) sys_count <= sys_count + 64'h1;

  // Hang guard: far above the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic end_of_test();
    if (err_total == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Address and data offered together, each released when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic axr(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask

  // One error report; a classless report is not recorded, so no timestamp
  task automatic inj(input logic [1:0] k, input logic c);
    @(posedge clk);
    err_in <= {1'b1, k, c, 8'h5a, 6'h00, k};
    #1 if (k != 2'h0) ts_last = sys_count;
    @(posedge clk);
    err_in.valid <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {clk, err_rec_rst, err_in, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    rst = 1'b1;
    s_axi_wstrb = 4'hf;
    sys_count = 64'h0000_0001_ffff_ffe0;
    {err_total, cmp_count, cyc} = '0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    axr(enis_pkg::CTRL_OFS);
    chk(d, {26'h0, enis_pkg::CTRL_RESET});
    axr(enis_pkg::STAT_OFS);
    chk(d, {25'h0, enis_pkg::STAT_RESET});
    for (int i = 0; i < 14; i++) begin
      axw(enis_pkg::CTRL_OFS, {26'h0, rows[i][11:6]});
      axw(enis_pkg::STAT_OFS, 32'h7f);
      f0 = f_cnt;
      r0 = r_cnt;
      c0 = c_cnt;
      inj(rows[i][5:4], rows[i][3]);
      if (rows[i][11]) begin
        chk(32'({f_cnt - f0, r_cnt - r0, c_cnt - c0}),
            32'({7'h0, rows[i][2], 7'h0, rows[i][1], 7'h0, rows[i][0]}));
        chk(32'(irq_out), 32'h0);
      end else chk(32'(irq_out), 32'(rows[i][2:0]));
      axr(enis_pkg::TSLO_OFS);
      chk(d, ts_last[31:0]);
    end
    // Clearing the flags drops a level request
    axw(enis_pkg::CTRL_OFS, 32'h01);
    axw(enis_pkg::STAT_OFS, 32'h7f);
    inj(2'h3, 1'b0);
    chk(32'(irq_out), 32'h4);
    axw(enis_pkg::STAT_OFS, 32'h7f);
    repeat (3) @(posedge clk);
    chk(32'(irq_out), 32'h0);
    // Recovery reset keeps the record but drops enables and requests
    inj(2'h3, 1'b0);
    @(posedge clk);
    err_rec_rst <= 1'b1;
    @(posedge clk);
    err_rec_rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk(32'(irq_out), 32'h0);
    axr(enis_pkg::STAT_OFS);
    chk(d & 32'h7f, 32'h03);
    axr(enis_pkg::SYND_OFS);
    chk(d & 32'hffff, 32'h5a03);
    axr(enis_pkg::CTRL_OFS);
    chk(d, 32'h0);
    // Counter overflow is the corrected event, level then edge
    axw(enis_pkg::CTRL_OFS, 32'h02);
    axw(enis_pkg::STAT_OFS, 32'h7f);
    axw(enis_pkg::CECNT_OFS, 32'hff);
    inj(2'h1, 1'b0);
    chk(32'(irq_out), 32'h4);
    axr(enis_pkg::CECNT_OFS);
    chk(d & 32'hff, 32'h0);
    axw(enis_pkg::CTRL_OFS, 32'h20);
    axw(enis_pkg::STAT_OFS, 32'h7f);
    inj(2'h3, 1'b0);
    f0 = f_cnt;
    axw(enis_pkg::CTRL_OFS, 32'h21);
    repeat (4) @(posedge clk);
    chk(32'(f_cnt - f0), 32'h0);
    axw(enis_pkg::STAT_OFS, 32'h7f);
    axw(enis_pkg::CTRL_OFS, 32'h22);
    axw(enis_pkg::CECNT_OFS, 32'hff);
    f0 = f_cnt;
    inj(2'h1, 1'b0);
    chk(32'(f_cnt - f0), 32'h1);
    // Back-to-back critical reports, the second dropped by priority
    axw(enis_pkg::STAT_OFS, 32'h7f);
    axw(enis_pkg::CTRL_OFS, 32'h31);
    f0 = f_cnt;
    c0 = c_cnt;
    @(posedge clk);
    err_in <= {1'b1, 2'h3, 1'b1, 16'haaaa};
    @(posedge clk);
    err_in <= {1'b1, 2'h2, 1'b1, 16'h5555};
    @(posedge clk);
    err_in.valid <= 1'b0;
    repeat (4) @(posedge clk);
    chk(32'({f_cnt - f0, c_cnt - c0}), 32'h0202);
    axr(enis_pkg::SYND_OFS);
    chk(d & 32'hffff, 32'haaaa);
    // Refused accesses and the fixed feature word
    axr(8'h04);
    chk(d, 32'h0);
    chk(32'(r), 32'(enis_pkg::RESP_SLVERR));
    axw(enis_pkg::FEAT_OFS, 32'h0);
    chk(32'(r), 32'(enis_pkg::RESP_SLVERR));
    axr(enis_pkg::FEAT_OFS);
    chk(d, {27'h0, enis_pkg::FEAT_HAS_CECNT, enis_pkg::FEAT_CI_SEL, enis_pkg::FEAT_TS_SEL});
    // Cold reset in mid-run wipes the record
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    axr(enis_pkg::STAT_OFS);
    chk(d, 32'h0);
    axr(enis_pkg::SYND_OFS);
    chk(d, 32'h0);
    end_of_test();
  end
endmodule // enis_node_bench

bind enis_node enis_node_properties chk_u (.*);

// ---- testbench/enis_node_properties.sv ----
// Port-level checker for the error node interrupt signaling block
`timescale 1ns/1ps
module enis_node_properties (
  input wire logic                clk,
  input wire logic                rst,
  input wire logic                err_rec_rst,
  input wire enis_pkg::enis_err_t err_in,
  input wire logic                s_axi_wvalid,
  input wire logic                s_axi_wready,
  input wire logic [1:0]          s_axi_bresp,
  input wire logic                s_axi_bvalid,
  input wire logic                s_axi_bready,
  input wire logic [7:0]          s_axi_araddr,
  input wire logic                s_axi_arvalid,
  input wire logic                s_axi_arready,
  input wire logic [31:0]         s_axi_rdata,
  input wire logic [1:0]          s_axi_rresp,
  input wire logic                s_axi_rvalid,
  input wire logic                s_axi_rready,
  input wire enis_pkg::enis_irq_t irq_out
);
  // ----------------------------------------------------------------
  // Helpers and properties
  // ----------------------------------------------------------------
  logic [3:0] cause_age, crit_age;
  logic       rd_bad, rd_feat;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Cycles since the last thing that may raise a request; saturates
  always_ff @(posedge clk) begin
    if (rst) begin
      cause_age <= 4'hf;
      crit_age  <= 4'hf;
    end else begin
      if (err_in.valid || (s_axi_wvalid && s_axi_wready)) cause_age <= 4'h0;
      else if (cause_age != 4'hf) cause_age <= cause_age + 4'h1;
      if ((err_in.valid && err_in.critical) || (s_axi_wvalid && s_axi_wready)) crit_age <= 4'h0;
      else if (crit_age != 4'hf) crit_age <= crit_age + 4'h1;
    end
  end

  // Remember what kind of place the pending read targets
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_bad  <= 1'b0;
      rd_feat <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rd_bad  <= !(s_axi_araddr inside {enis_pkg::FEAT_OFS, enis_pkg::CTRL_OFS,
                   enis_pkg::STAT_OFS, enis_pkg::SYND_OFS, enis_pkg::CECNT_OFS,
                   enis_pkg::TSLO_OFS, enis_pkg::TSHI_OFS});
      rd_feat <= (s_axi_araddr == enis_pkg::FEAT_OFS);
    end
  end

  property p_cold_clear;
    $fell(rst) |-> irq_out == 3'b000;
  endproperty
  a_cold_clear: assert property (p_cold_clear)
    else $error("lines not clear after cold reset");
  property p_rec_clear;
    err_rec_rst |=> irq_out == 3'b000;
  endproperty
  a_rec_clear: assert property (p_rec_clear)
    else $error("interrupt lines not clear after recovery reset");
  property p_irq_cause;
    ($rose(irq_out.fault) || $rose(irq_out.recovery)) |-> cause_age <= 4'h3;
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("request raised without cause");
  property p_crit_cause;
    $rose(irq_out.critical) |-> crit_age <= 4'h3;
  endproperty
  a_crit_cause: assert property (p_crit_cause)
    else $error("critical request raised without cause");
  property p_read_answer;
    s_axi_arvalid && s_axi_arready |=> ##[0:1] s_axi_rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read not answered");
  property p_read_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
  endproperty
  a_read_hold: assert property (p_read_hold)
    else $error("read answer changed before rready");
  property p_write_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_write_hold: assert property (p_write_hold)
    else $error("write answer changed before bready");
  property p_unmapped;
    s_axi_rvalid && rd_bad |-> s_axi_rresp == enis_pkg::RESP_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not refused");
  property p_feature;
    s_axi_rvalid && rd_feat |-> s_axi_rdata[4:0] ==
      {enis_pkg::FEAT_HAS_CECNT, enis_pkg::FEAT_CI_SEL, enis_pkg::FEAT_TS_SEL};
  endproperty
  a_feature: assert property (p_feature)
    else $error("feature word wrong");
  c_fault: cover property ($rose(irq_out.fault));
  c_crit: cover property ($rose(irq_out.critical));
  c_slverr: cover property (s_axi_rvalid && rd_bad);
endmodule // enis_node_properties
